//--- design/psi_pkg.sv
package psi_pkg;
  // Program counter, stack and data pointer geometry
  localparam int PC_W = 13;
  localparam int STK_DEPTH = 8;
  localparam logic [2:0] SP_RESET = 3'h7;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam int DP_W = 10;
  localparam int NSRC = 4;
  localparam int RAM_WORDS = 288;
  localparam logic [5:0] VEC_PAGE = 6'h01;
  localparam logic [5:0] SUB_PAGE = 6'h02;
  localparam logic [6:0] VEC_OFS [4] = '{7'h00, 7'h04, 7'h06, 7'h08};
  // Interrupt latency in machine cycles
  localparam logic [1:0] LAT_SHORT = 2'h2;
  localparam logic [1:0] LAT_LONG = 2'h3;
  // APB map
  localparam logic [7:0] OFS_SRC_EN = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_PC = 8'h08;
  localparam logic [7:0] OFS_CTX = 8'h0C;
  localparam logic [3:0] SRC_EN_RESET = 4'h0;
  localparam int ST_REQ_LSB = 0;
  localparam int ST_GLOBAL_IRQ_ENABLE_BIT = 4;
  localparam int ST_SP_LSB = 5;
  localparam int ST_SKIP_BIT = 8;

  typedef enum logic [4:0] {
    OP_NOP, OP_BRANCH, OP_CALL, OP_PAGE2_CALL, OP_RETURN, OP_IRQ_RETURN,
    OP_TABLE, OP_EI, OP_DI, OP_COPY_SP, OP_POLL, OP_SKIP_COND,
    OP_BIT_SET, OP_BIT_CLR, OP_BIT_TEST, OP_RAM_WR,
    OP_PORT_SET, OP_PORT_CLR, OP_PORT_TEST, OP_LOAD_DP
  } psi_op_t;

  typedef enum logic [1:0] {
    ST_RUN       = 2'b00,
    ST_TBL_FETCH = 2'b01,
    ST_TBL_RET   = 2'b11
  } psi_state_t;

  typedef struct packed {
    logic [9:0] dp;
    logic       carry;
    logic       skip;
    logic [3:0] acc;
    logic [3:0] regb;
  } psi_ctx_t;
endpackage

//--- design/psi_mem_if.sv
interface psi_mem_if #(parameter int AW = 3, parameter int DW = 13);
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport ctrl (output we, waddr, wdata, raddr, input rdata);
  modport mem  (input we, waddr, wdata, raddr, output rdata);
endinterface

//--- design/psi_stack.sv
module psi_stack (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Stack port
  psi_mem_if.mem   port
);
  logic [12:0] mem_r [psi_pkg::STK_DEPTH];

  // Entries: a push past the top silently overwrites the oldest
  always_ff @(posedge pclk) begin
    if (port.we) begin
      mem_r[port.waddr] <= port.wdata;
    end
  end

  // Registered read, write-first so the top is always current
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port.rdata <= '0;
    end else if (port.we && port.waddr == port.raddr) begin
      port.rdata <= port.wdata;
    end else begin
      port.rdata <= mem_r[port.raddr];
    end
  end
endmodule

//--- design/psi_ram.sv
module psi_ram (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data port, address is {group, file, digit}
  psi_mem_if.mem   port
);
  logic [3:0] mem_r [psi_pkg::RAM_WORDS];
  logic       wr_ok;
  logic       rd_ok;

  // Group 1 stops after file 1; beyond it reads zero, writes drop
  assign wr_ok = !port.waddr[9] && port.waddr[8:0] < 9'(psi_pkg::RAM_WORDS);
  assign rd_ok = !port.raddr[9] && port.raddr[8:0] < 9'(psi_pkg::RAM_WORDS);

  always_ff @(posedge pclk) begin
    if (port.we && wr_ok) begin
      mem_r[port.waddr[8:0]] <= port.wdata;
    end
  end

  // Write-first registered read of the word under the pointer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port.rdata <= 4'h0;
    end else if (!rd_ok) begin
      port.rdata <= 4'h0;
    end else if (port.we && port.waddr == port.raddr) begin
      port.rdata <= port.wdata;
    end else begin
      port.rdata <= mem_r[port.raddr[8:0]];
    end
  end
endmodule

//--- design/psi_core.sv
// Summary of operation
// - Return-address stack has exactly eight entries, nesting eight deep.
// - Interrupt entry and table lookup each use one entry of that stack.
// - A push at level seven wraps to zero, overwriting entry zero.
// - A 3-bit pointer tracks the level; one instruction copies it out.
// - Pointer is seven after reset or back-up exit; first call uses entry zero.
// - Interrupt entry saves RAM pointer, carry, skip, accumulator, register B once.
// - Calls and table lookups never touch the interrupt context save.
// - Skip flag steers skips and survives an interrupt through the save.
// - PC advances by word count, or loads a target on jumps and returns.
// - PC has page bits above an in-page part 6..0; 127 rolls to next page.
// - RAM pointer holds group, file and digit fields.
// - Digit field also picks the port bit for set, clear and test.
// - Group field has no reset; software loads all fields after back-up.
// - Program words are 10 bits, pages of 128 words, up to 64 pages.
// - Acceptance loads the source's fixed vector in page 1.
// - Page-two call reaches page 2 from anywhere with one word.
// - Table lookup returns low eight bits of any program word.
// - RAM holds 288 nibbles; bit set, clear, test work on any of them.
// - Take only when request, source enable and global enable are all one.
// - Enable and disable instructions steer global enable; acceptance clears it.
// - Source enable zero selects polling by its skip test instead.
// - Request flags set regardless of enables and stay until serviced.
// - Priority external pin, then timers 1, 2, 3; vectors 0, 4, 6, 8.
// - Acceptance clears only the serviced source's request flag.
// - Taken two cycles after conditions, three inside a multi-cycle instruction.
// - Return instruction ends service; enable acts after the next instruction.
//
// Implementation choices: the address map and the APB slave port.
module psi_core (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Instruction decoder
  input  wire logic              op_valid,
  input  wire psi_pkg::psi_op_t  op_code,
  input  wire logic [1:0]        op_words,
  input  wire logic              op_multi,
  input  wire logic [12:0]       op_target,
  input  wire logic [1:0]        op_sel,
  input  wire logic              op_cond,
  input  wire logic [3:0]        acc_in,
  input  wire logic [3:0]        regb_in,
  input  wire logic              carry_in,
  input  wire logic [9:0]        rom_data,
  input  wire logic              backup_exit,
  output logic      [12:0]       pc,
  output logic                   op_hold,
  output logic                   skip_flag,
  output logic      [7:0]        result,
  output logic                   result_valid,
  output logic                   irq_take,
  output logic      [1:0]        irq_src,
  output logic                   ctx_restore,
  output logic      [3:0]        ctx_acc,
  output logic      [3:0]        ctx_regb,
  output logic                   ctx_carry,
  // Interrupt sources and port D
  input  wire logic [3:0]        src_event,
  input  wire logic [7:0]        port_d_in,
  output logic      [7:0]        port_d_out
);
  psi_mem_if #(.AW(3), .DW(13)) stk_if ();
  psi_mem_if #(.AW(10), .DW(4)) ram_if ();

  psi_pkg::psi_state_t state_r, st_nxt;
  psi_pkg::psi_ctx_t   ctx_r;
  logic [12:0] pc_r, pc_nxt, push_val;
  logic [2:0]  sp_r, sp_nxt;
  logic [1:0]  z_r;
  logic [3:0]  x_r, y_r;
  logic [9:0]  dp_cur, dp_nxt;
  logic [3:0]  req_r, src_en_r, eligible, take_mask, poll_clr;
  logic [1:0]  sel_idx, cnt_r, cnt_nxt, irq_src_r;
  logic        global_irq_enable_r, ei_arm_r, skip_r, skip_nxt, hold_r;
  logic        irq_cond, take, op_go, stk_push, stk_pop;
  logic        take_r, restore_r, res_valid_r;
  logic [7:0]  res_r, port_d_r;
  logic [3:0]  ram_wdata;
  logic [31:0] rd_word, prdata_r;
  logic        pready_r, pslverr_r, rd_hit;

  psi_stack u_stack (.pclk(pclk), .presetn(presetn), .port(stk_if.mem));
  psi_ram   u_ram   (.pclk(pclk), .presetn(presetn), .port(ram_if.mem));

  // Eligibility and fixed priority, lowest index first
  assign eligible = req_r & src_en_r;
  assign irq_cond = global_irq_enable_r && (eligible != 4'h0);
  always_comb begin
    sel_idx = 2'h0;
    for (int i = psi_pkg::NSRC - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        sel_idx = 2'(i);
      end
    end
  end

  // Latency counter; a condition that drops before the take cancels it
  assign take = (cnt_r == 2'h1) && irq_cond && state_r == psi_pkg::ST_RUN;
  always_comb begin
    if (take || cnt_r == 2'h1) begin
      cnt_nxt = 2'h0;
    end else if (cnt_r != 2'h0) begin
      cnt_nxt = cnt_r - 2'h1;
    end else if (irq_cond && state_r == psi_pkg::ST_RUN) begin
      cnt_nxt = op_multi ? psi_pkg::LAT_LONG - 2'h1 : psi_pkg::LAT_SHORT - 2'h1;
    end else begin
      cnt_nxt = 2'h0;
    end
  end
  assign take_mask = take ? (4'h1 << sel_idx) : 4'h0;
  assign op_go = op_valid && !take && state_r == psi_pkg::ST_RUN;

  // Sequencer: PC, stack pointer and table-lookup steps
  always_comb begin
    pc_nxt = pc_r;
    st_nxt = state_r;
    stk_push = 1'b0;
    stk_pop = 1'b0;
    push_val = pc_r;
    case (state_r)
      psi_pkg::ST_RUN: begin
        if (take) begin
          stk_push = 1'b1;
          pc_nxt = {psi_pkg::VEC_PAGE, psi_pkg::VEC_OFS[sel_idx]};
        end else if (op_go) begin
          pc_nxt = pc_r + {11'h000, op_words};
          push_val = pc_r + {11'h000, op_words};
          case (op_code)
            psi_pkg::OP_BRANCH: begin
              pc_nxt = op_target;
            end
            psi_pkg::OP_CALL: begin
              stk_push = 1'b1;
              pc_nxt = op_target;
            end
            psi_pkg::OP_PAGE2_CALL: begin
              stk_push = 1'b1;
              pc_nxt = {psi_pkg::SUB_PAGE, op_target[6:0]};
            end
            psi_pkg::OP_RETURN, psi_pkg::OP_IRQ_RETURN: begin
              stk_pop = 1'b1;
              pc_nxt = stk_if.rdata;
            end
            psi_pkg::OP_TABLE: begin
              stk_push = 1'b1;
              pc_nxt = op_target;
              st_nxt = psi_pkg::ST_TBL_FETCH;
            end
            default: begin
            end
          endcase
        end
      end
      psi_pkg::ST_TBL_FETCH: begin
        st_nxt = psi_pkg::ST_TBL_RET;
      end
      psi_pkg::ST_TBL_RET: begin
        stk_pop = 1'b1;
        pc_nxt = stk_if.rdata;
        st_nxt = psi_pkg::ST_RUN;
      end
      default: begin
        st_nxt = psi_pkg::ST_RUN;
      end
    endcase
  end

  // Level pointer wraps modulo eight both ways
  always_comb begin
    sp_nxt = sp_r;
    if (backup_exit) begin
      sp_nxt = psi_pkg::SP_RESET;
    end else if (stk_push) begin
      sp_nxt = sp_r + 3'h1;
    end else if (stk_pop) begin
      sp_nxt = sp_r - 3'h1;
    end
  end
  assign stk_if.we = stk_push;
  assign stk_if.waddr = sp_nxt;
  assign stk_if.wdata = push_val;
  assign stk_if.raddr = sp_nxt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r <= psi_pkg::PC_RESET;
      sp_r <= psi_pkg::SP_RESET;
      state_r <= psi_pkg::ST_RUN;
      cnt_r <= 2'h0;
      hold_r <= 1'b0;
    end else begin
      pc_r <= pc_nxt;
      sp_r <= sp_nxt;
      state_r <= st_nxt;
      cnt_r <= cnt_nxt;
      hold_r <= (st_nxt != psi_pkg::ST_RUN) || (cnt_nxt != 2'h0);
    end
  end

  // RAM pointer; the group field deliberately has no reset
  assign dp_cur = {z_r, x_r, y_r};
  always_comb begin
    dp_nxt = dp_cur;
    if (op_go && op_code == psi_pkg::OP_LOAD_DP) begin
      dp_nxt = op_target[9:0];
    end else if (op_go && op_code == psi_pkg::OP_IRQ_RETURN) begin
      dp_nxt = ctx_r.dp;
    end
  end
  always_ff @(posedge pclk) begin
    z_r <= dp_nxt[9:8];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      x_r <= 4'h0;
      y_r <= 4'h0;
    end else begin
      x_r <= dp_nxt[7:4];
      y_r <= dp_nxt[3:0];
    end
  end

  // Bit operations modify the word the pointer addresses
  always_comb begin
    ram_wdata = ram_if.rdata;
    case (op_code)
      psi_pkg::OP_BIT_SET: ram_wdata[op_sel] = 1'b1;
      psi_pkg::OP_BIT_CLR: ram_wdata[op_sel] = 1'b0;
      default: ram_wdata = acc_in;
    endcase
  end
  assign ram_if.we = op_go && (op_code == psi_pkg::OP_BIT_SET ||
                     op_code == psi_pkg::OP_BIT_CLR || op_code == psi_pkg::OP_RAM_WR);
  assign ram_if.waddr = dp_cur;
  assign ram_if.wdata = ram_wdata;
  assign ram_if.raddr = dp_nxt;

  // Skip decision; a poll only skips when its source is not enabled
  always_comb begin
    skip_nxt = skip_r;
    poll_clr = 4'h0;
    if (take) begin
      skip_nxt = 1'b0;
    end else if (op_go) begin
      case (op_code)
        psi_pkg::OP_SKIP_COND: skip_nxt = op_cond;
        psi_pkg::OP_BIT_TEST: skip_nxt = !ram_if.rdata[op_sel];
        psi_pkg::OP_PORT_TEST: skip_nxt = !port_d_in[y_r[2:0]];
        psi_pkg::OP_IRQ_RETURN: skip_nxt = ctx_r.skip;
        psi_pkg::OP_POLL: begin
          skip_nxt = req_r[op_sel] && !src_en_r[op_sel];
          poll_clr = skip_nxt ? (4'h1 << op_sel) : 4'h0;
        end
        default: skip_nxt = 1'b0;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_r <= 1'b0;
    end else begin
      skip_r <= skip_nxt;
    end
  end

  // Request flags: a new event beats a same-cycle clear
  for (genvar g = 0; g < psi_pkg::NSRC; g++) begin : g_req
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        req_r[g] <= 1'b0;
      end else begin
        req_r[g] <= (req_r[g] && !(take_mask[g] || poll_clr[g])) || src_event[g];
      end
    end
  end

  // Global enable; enable arms and bites after the following instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_irq_enable_r <= 1'b0;
      ei_arm_r <= 1'b0;
    end else if (take) begin
      global_irq_enable_r <= 1'b0;
      ei_arm_r <= 1'b0;
    end else if (op_go && op_code == psi_pkg::OP_DI) begin
      global_irq_enable_r <= 1'b0;
      ei_arm_r <= 1'b0;
    end else if (op_go && op_code == psi_pkg::OP_EI) begin
      ei_arm_r <= 1'b1;
    end else if (op_go && ei_arm_r) begin
      global_irq_enable_r <= 1'b1;
      ei_arm_r <= 1'b0;
    end
  end

  // Single-stage context, written by interrupt entry only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctx_r <= '0;
    end else if (take) begin
      ctx_r <= '{dp: dp_cur, carry: carry_in, skip: skip_r,
                 acc: acc_in, regb: regb_in};
    end
  end

  // Event outputs and results toward the decoder
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      take_r <= 1'b0;
      irq_src_r <= 2'h0;
      restore_r <= 1'b0;
      res_r <= 8'h00;
      res_valid_r <= 1'b0;
    end else begin
      take_r <= take;
      irq_src_r <= take ? sel_idx : irq_src_r;
      restore_r <= op_go && op_code == psi_pkg::OP_IRQ_RETURN;
      res_valid_r <= state_r == psi_pkg::ST_TBL_RET ||
                     (op_go && op_code == psi_pkg::OP_COPY_SP);
      if (state_r == psi_pkg::ST_TBL_RET) begin
        res_r <= rom_data[7:0];
      end else if (op_go && op_code == psi_pkg::OP_COPY_SP) begin
        res_r <= {5'h00, sp_r};
      end
    end
  end

  // Port D latches, bit picked by the digit field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_d_r <= 8'h00;
    end else if (op_go && op_code == psi_pkg::OP_PORT_SET) begin
      port_d_r[y_r[2:0]] <= 1'b1;
    end else if (op_go && op_code == psi_pkg::OP_PORT_CLR) begin
      port_d_r[y_r[2:0]] <= 1'b0;
    end
  end

  // APB: answer one cycle after setup, so no wait states
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      psi_pkg::OFS_SRC_EN: rd_word[3:0] = src_en_r;
      psi_pkg::OFS_STATUS: begin
        rd_word[psi_pkg::ST_REQ_LSB +: 4] = req_r;
        rd_word[psi_pkg::ST_GLOBAL_IRQ_ENABLE_BIT] = global_irq_enable_r;
        rd_word[psi_pkg::ST_SP_LSB +: 3] = sp_r;
        rd_word[psi_pkg::ST_SKIP_BIT] = skip_r;
      end
      psi_pkg::OFS_PC: rd_word[12:0] = pc_r;
      psi_pkg::OFS_CTX: rd_word[19:0] = ctx_r;
      default: rd_hit = 1'b0;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= psel && !penable;
      if (psel && !penable) begin
        pslverr_r <= !rd_hit;
        prdata_r <= pwrite ? 32'h0000_0000 : rd_word;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_en_r <= psi_pkg::SRC_EN_RESET;
    end else if (psel && penable && pready_r && pwrite && paddr == psi_pkg::OFS_SRC_EN) begin
      src_en_r <= pwdata[3:0];
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign pc = pc_r;
  assign op_hold = hold_r;
  assign skip_flag = skip_r;
  assign result = res_r;
  assign result_valid = res_valid_r;
  assign irq_take = take_r;
  assign irq_src = irq_src_r;
  assign ctx_restore = restore_r;
  assign ctx_acc = ctx_r.acc;
  assign ctx_regb = ctx_r.regb;
  assign ctx_carry = ctx_r.carry;
  assign port_d_out = port_d_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_call_wraps:
    assert property (op_go && op_code == psi_pkg::OP_CALL && sp_r == 3'h7 && !backup_exit
                     |=> sp_r == 3'h0) else $error("call at level 7 did not wrap");
  chk_reset_level:
    assert property ($rose(presetn) |-> sp_r == 3'h7) else $error("level not 7 after reset");
  chk_vector_page:
    assert property (take_r |-> pc_r[12:7] == psi_pkg::VEC_PAGE && pc_r[0] == 1'b0)
    else $error("entry not in vector page");
  chk_all_enables:
    assert property (take |-> global_irq_enable_r && (req_r & src_en_r) != 4'h0)
    else $error("taken without all enables");
  chk_take_clears:
    assert property (take ##1 !(op_go && ei_arm_r) |-> !global_irq_enable_r)
    else $error("global enable survived entry");
  chk_two_cycles:
    assert property (cnt_r == 2'h0 && irq_cond && state_r == psi_pkg::ST_RUN && !op_multi
                     ##1 irq_cond |-> take) else $error("entry not two cycles after");
  chk_ctx_only_irq:
    assert property (!$stable(ctx_r) |-> $past(take)) else $error("context written without entry");
  chk_enable_delay:
    assert property (op_go && op_code == psi_pkg::OP_EI && !global_irq_enable_r |=> !global_irq_enable_r)
    else $error("enable acted at once");
  chk_event_wins:
    assert property (src_event[0] |=> req_r[0]) else $error("request event lost");
  chk_one_cleared:
    assert property (take |=> (req_r | $past(take_mask)) == ($past(req_r) | req_r) &&
                     (req_r & $past(take_mask & ~src_event)) == 4'h0)
    else $error("other request flags cleared");

  cov_irq_taken: cover property (take_r ##[1:20] restore_r);
  cov_table_read: cover property (state_r == psi_pkg::ST_TBL_RET ##1 res_valid_r);
  cov_wrap: cover property (stk_push && sp_r == 3'h7);
  cov_poll_skip: cover property (poll_clr != 4'h0);
endmodule

//--- tb/psi_rom_model.sv
module psi_rom_model (
  // Clock
  input  wire logic        pclk,
  // Program fetch
  input  wire logic [12:0] pc,
  output logic      [9:0]  rom_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // Word is a scramble of its address, so any table target is predictable
  always_ff @(posedge pclk) begin
    rom_data <= pc[9:0] ^ 10'h2A5;
  end
endmodule

//--- tb/tb_program_sequencer_interrupt.sv
module tb_program_sequencer_interrupt;
  timeunit 1ns;
  timeprecision 1ns;
  logic              pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic              op_valid = 0, op_multi = 0, op_cond = 0, backup_exit = 0, carry_in = 0;
  logic              pready, pslverr, op_hold, skip_flag, result_valid, irq_take;
  logic              ctx_restore, ctx_carry;
  logic [7:0]        paddr = 8'h00, port_d_in = 8'h5A, result, port_d_out;
  logic [31:0]       pwdata = 32'h0, prdata, q, obs, exq[$];
  logic [1:0]        op_words = 2'h1, op_sel = 2'h0, irq_src;
  logic [12:0]       op_target = 13'h0, pc, xpc, t, ret[8];
  logic [3:0]        acc_in = 4'h0, regb_in = 4'h0, src_event = 4'h0, ctx_acc, ctx_regb;
  logic [9:0]        rom_data;
  psi_pkg::psi_op_t  op_code = psi_pkg::OP_NOP;
  int                failures = 0, checks_done = 0;

  // Machine cycle clock
  always #5 pclk = ~pclk;

  psi_core i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .op_valid, .op_code, .op_words, .op_multi, .op_target, .op_sel,
    .op_cond, .acc_in, .regb_in, .carry_in, .rom_data, .backup_exit, .pc, .op_hold,
    .skip_flag, .result, .result_valid, .irq_take, .irq_src, .ctx_restore, .ctx_acc,
    .ctx_regb, .ctx_carry, .src_event, .port_d_in, .port_d_out);
  psi_rom_model i_rom (.pclk, .pc, .rom_data);

  task chk(input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      failures++;
      $display("FAIL t=%0t exp=%h got=%h", $time, x, g);
    end
  endtask

  task complete_run;
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // Instruction stays offered until an edge with hold low takes it
  task op(input psi_pkg::psi_op_t c, input logic [12:0] tg, input logic [1:0] s);
    @(posedge pclk);
    op_valid <= 1'b1; op_code <= c; op_target <= tg; op_sel <= s;
    @(negedge pclk);
    while (op_hold !== 1'b0) @(negedge pclk);
    @(posedge pclk);
    op_valid <= 1'b0;
  endtask

  // Counts falling edges until the event shows; a timeout leaves n at 20
  task wait_evt(input bit c, input int x);
    int n;
    n = 0;
    while ((c ? ctx_restore : irq_take) !== 1'b1 && n < 20) begin
      @(negedge pclk);
      n++;
    end
    chk(x, n);
  endtask

  // Results and entries checked against the oldest note
  always @(negedge pclk) if (result_valid === 1'b1 || irq_take === 1'b1) begin
    obs = result_valid ? {24'h0, result} : {17'h1, irq_src, pc};
    if (exq.size() == 0) chk(32'hDEAD, obs);
    else chk(exq.pop_front(), obs);
  end

  // Watchdog, well past the few hundred cycles the run needs
  initial begin
    #100000;
    failures++;
    complete_run;
  end

  initial begin
    void'($urandom(74));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    acc_in <= 4'($urandom);
    regb_in <= 4'($urandom);
    apb(0, psi_pkg::OFS_STATUS, 0);
    chk(32'hE0, q);
    apb(0, 8'h10, 0);
    chk(32'h1, {31'h0, e});
    exq.push_back(32'h7);
    op(psi_pkg::OP_COPY_SP, 0, 0);
    // Nine calls: the ninth wraps the level and overwrites entry zero
    xpc = 13'h1;
    for (int i = 0; i < 9; i++) begin
      ret[i % 8] = xpc + 13'h1;
      xpc = 13'h100 + 13'(8 * i);
      op(psi_pkg::OP_CALL, xpc, 0);
      exq.push_back(i % 8);
      op(psi_pkg::OP_COPY_SP, 0, 0);
      xpc = xpc + 13'h1;
    end
    foreach (ret[j]) if (j == 0 || j == 7) begin
      op(psi_pkg::OP_RETURN, 0, 0);
      apb(0, psi_pkg::OFS_PC, 0);
      chk({19'h0, ret[j]}, q);
    end
    exq.push_back(32'h6);
    op(psi_pkg::OP_COPY_SP, 0, 0);
    t = 13'($urandom);
    exq.push_back({24'h0, t[7:0] ^ 8'hA5});
    op(psi_pkg::OP_TABLE, t, 0);
    // Let the fetch and the pop finish before the counter is read
    repeat (2) @(posedge pclk);
    apb(0, psi_pkg::OFS_PC, 0);
    chk({19'h0, ret[7] + 13'h2}, q);
    op(psi_pkg::OP_BRANCH, 13'h007F, 0);
    op(psi_pkg::OP_NOP, 0, 0);
    apb(0, psi_pkg::OFS_PC, 0);
    chk(32'h80, q);
    // Page-two call ignores the upper target bits
    op(psi_pkg::OP_PAGE2_CALL, 13'h1F45, 0);
    apb(0, psi_pkg::OFS_PC, 0);
    chk(32'h145, q);
    op(psi_pkg::OP_RETURN, 0, 0);
    // Pointer at group 0, file 3, digit 5 for port and RAM bits
    op(psi_pkg::OP_LOAD_DP, 13'h0035, 0);
    op(psi_pkg::OP_PORT_SET, 0, 0);
    @(negedge pclk);
    chk(32'h20, port_d_out);
    op(psi_pkg::OP_PORT_CLR, 0, 0);
    @(negedge pclk);
    chk(32'h00, port_d_out);
    op(psi_pkg::OP_RAM_WR, 0, 0);
    op(psi_pkg::OP_BIT_TEST, 0, 2'h2);
    @(negedge pclk);
    chk(!acc_in[2], skip_flag);
    // Two requests while disabled, source three left to polling
    apb(1, psi_pkg::OFS_SRC_EN, 32'h7);
    src_event <= 4'h6;
    @(posedge pclk) src_event <= 4'h0;
    apb(0, psi_pkg::OFS_STATUS, 0);
    chk(32'h06, q & 32'h1F);
    exq.push_back({17'h1, 2'h1, 13'h084});
    op(psi_pkg::OP_EI, 0, 0);
    op(psi_pkg::OP_NOP, 0, 0);
    wait_evt(0, psi_pkg::LAT_SHORT + 1);
    apb(0, psi_pkg::OFS_STATUS, 0);
    chk(32'h04, q & 32'h1F);
    apb(0, psi_pkg::OFS_CTX, 0);
    chk({12'h000, 10'h035, 2'b00, acc_in, regb_in}, q);
    op(psi_pkg::OP_IRQ_RETURN, 0, 0);
    wait_evt(1, 1);
    chk({acc_in, regb_in}, {ctx_acc, ctx_regb});
    @(posedge pclk) src_event <= 4'h8;
    @(posedge pclk) src_event <= 4'h0;
    // Enable withdrawn before it bites: nothing may be taken
    op(psi_pkg::OP_EI, 0, 0);
    op(psi_pkg::OP_DI, 0, 0);
    op(psi_pkg::OP_NOP, 0, 0);
    apb(0, psi_pkg::OFS_STATUS, 0);
    chk(32'h0C, q & 32'h1F);
    exq.push_back({17'h1, 2'h2, 13'h086});
    // Conditions met inside a multi-cycle instruction: one cycle later
    op_multi <= 1'b1;
    op(psi_pkg::OP_EI, 0, 0);
    op(psi_pkg::OP_NOP, 0, 0);
    wait_evt(0, psi_pkg::LAT_LONG + 1);
    @(posedge pclk) op_multi <= 1'b0;
    op(psi_pkg::OP_IRQ_RETURN, 0, 0);
    wait_evt(1, 1);
    op(psi_pkg::OP_POLL, 0, 2'h3);
    @(negedge pclk);
    chk(1, skip_flag);
    @(posedge pclk) backup_exit <= 1'b1;
    @(posedge pclk) backup_exit <= 1'b0;
    apb(0, psi_pkg::OFS_STATUS, 0);
    chk(0, q & 32'hF);
    chk(32'hE0, q & 32'hE0);
    repeat (3) @(posedge pclk);
    chk(0, exq.size());
    complete_run;
  end
endmodule
